// >>> verilog/astc_pkg.sv
// Constants, field layouts, types and helpers for the asynchronous transmit channel.
// Assumes one 25 MHz reference clock; every pin is already synchronous to it.
package astc_pkg;
    localparam logic [2:0] PTR_CMD = 3'h0;
    localparam logic [2:0] PTR_IMR = 3'h1;
    localparam logic [2:0] PTR_VEC = 3'h2;
    localparam logic [2:0] PTR_RXC = 3'h3;
    localparam logic [2:0] PTR_AFC = 3'h4;
    localparam logic [2:0] PTR_TXC = 3'h5;
    localparam logic [2:0] CMD_RST_EXT   = 3'h2;
    localparam logic [2:0] CMD_CHAN_RST  = 3'h3;
    localparam logic [2:0] CMD_RST_TXINT = 3'h5;
    localparam int TXC_DTR = 7, TXC_LEN_LO = 5, TXC_BRK = 4, TXC_EN = 3, TXC_RTS = 1;
    localparam int RXC_LEN_LO = 6, RXC_AUTO = 5, RXC_EN = 0;
    localparam int AFC_CLK_LO = 6, AFC_STOP_LO = 2, AFC_EVEN = 1, AFC_PEN = 0;
    localparam int IMR_EXT = 0, IMR_TXI = 1, IMR_SAV = 2, IMR_RXI_LO = 3, IMR_WR = 7;
    localparam int ST_TBE = 2, ST_DCD = 3, ST_SYNC = 4, ST_CTS = 5, ST_BRK = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RD_NONE   = 8'h00;
    localparam logic [2:0] VEC_TBE = 3'h0;
    localparam logic [2:0] VEC_EXT = 3'h1;
    localparam logic [2:0] VEC_SRC = 3'h3;
    localparam int REF_PERIOD_NS = 40;
    localparam int MIN_PULSE_NS  = 200;
    localparam int BREAK_NS      = 4000;
    localparam logic [15:0] MIN_PULSE_CYC =
        16'((MIN_PULSE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    localparam logic [15:0] BREAK_CYC = 16'((BREAK_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    localparam int FIFO_W = 8;
    localparam int FIFO_DEPTH = 4;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       ctrl;
        logic [7:0] wdata;
    } astc_bus_s;

    typedef struct packed {
        logic       req;
        logic [1:0] cause;
    } astc_peer_s;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA  = 5'b00100,
        TX_PAR   = 5'b01000,
        TX_STOP  = 5'b10000
    } astc_tx_e;

    // Falling edges of the transmit clock per bit
    function automatic logic [6:0] astc_div(input logic [1:0] mode);
        case (mode)
            2'b00:   astc_div = 7'd1;
            2'b01:   astc_div = 7'd16;
            2'b10:   astc_div = 7'd32;
            default: astc_div = 7'd64;
        endcase
    endfunction : astc_div

    // Data bits of a written byte; five-or-fewer counts leading ones above a zero marker
    function automatic logic [3:0] astc_nbits(input logic [1:0] len, input logic [7:0] b);
        case (len)
            2'b10:   astc_nbits = 4'd6;
            2'b01:   astc_nbits = 4'd7;
            2'b11:   astc_nbits = 4'd8;
            default: begin
                if (!b[7])      astc_nbits = 4'd5;
                else if (!b[6]) astc_nbits = 4'd4;
                else if (!b[5]) astc_nbits = 4'd3;
                else if (!b[4]) astc_nbits = 4'd2;
                else            astc_nbits = 4'd1;
            end
        endcase
    endfunction : astc_nbits
endpackage : astc_pkg

// >>> verilog/astc_channel.sv
// Transmit FIFO and one asynchronous transmit channel with its write registers.
// Assumes the CPU bus, modem pins and transmit clock are all synchronous to i_ref_clk.
`timescale 1ns/1ps

module astc_fifo import astc_pkg::*; #(
    parameter int W     = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic         i_ref_clk,   // Reference clock
    input  wire logic         i_reset,     // Sync reset, active high
    input  wire logic         i_flush,     // Drop all words
    input  wire logic         i_in_valid,  // Write word offered
    input  wire logic [W-1:0] i_in_data,   // Word to store
    output logic              o_in_ready,  // Room for a word
    output logic              o_out_valid, // Head word present
    output logic [W-1:0]      o_out_data,  // Head word
    input  wire logic         i_out_ready  // Consumer takes head
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           rd;
        logic [AW-1:0]           wr;
        logic [AW:0]             count;
    } astc_fifo_s;
    astc_fifo_s s_q, s_d;
    logic push, pop;

    assign o_in_ready  = (s_q.count != (AW+1)'(DEPTH));
    assign o_out_valid = (s_q.count != '0);
    assign o_out_data  = s_q.mem[s_q.rd];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = i_out_ready && o_out_valid;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = i_in_data;
            s_d.wr = s_q.wr + AW'(1);
        end
        if (pop) s_d.rd = s_q.rd + AW'(1);
        s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
        if (i_flush) begin
            s_d.rd = '0;
            s_d.wr = '0;
            s_d.count = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) s_q <= '0;
        else         s_q <= s_d;
    end
endmodule : astc_fifo

module astc_channel import astc_pkg::*; (
    input  wire logic       i_ref_clk,      // 25 MHz reference clock
    input  wire logic       i_reset,        // Sync reset, active high
    input  wire astc_bus_s  i_bus,          // CPU write/read strobes, ctrl/data select
    input  wire logic       i_iack,         // Interrupt acknowledge strobe
    output logic [7:0]      o_rdata,        // Read or vector data
    output logic            o_rvalid,       // Read data valid pulse
    output logic            o_tx_ready,     // Transmit FIFO has room
    input  wire astc_peer_s i_peer,         // Higher-priority channel request
    input  wire logic       i_transmit_bit_clock, // Transmit clock pin
    input  wire logic       i_rxd,          // Received line, for break watch
    input  wire logic       i_cts_n,        // Clear to send, low active
    input  wire logic       i_dcd_n,        // Carrier detect, low active
    input  wire logic       i_sync_n,       // Sync pin, low active
    output logic            o_txd,          // Serial data out
    output logic            o_rts_n,        // Request to send, low active
    output logic            o_dtr_n,        // Terminal ready, low active
    output logic            o_rx_enabled,   // Receiver allowed to run
    output logic [3:0]      o_rx_bits,      // Receive character length
    output logic            o_wait_ready_en,// Wait/ready function enabled
    output logic [1:0]      o_rx_int_mode,  // Receive interrupt mode
    output logic            o_int           // Interrupt request, active high
);
    typedef struct packed {
        logic [2:0]       ptr;
        logic [7:0]       imr;
        logic [7:0]       vec;
        logic [7:0]       rxc;
        logic [7:0]       afc;
        logic [7:0]       transmit_bit_clock;
        astc_tx_e         st;
        logic [7:0]       sh;
        logic [3:0]       cnt;
        logic [6:0]       tick;
        logic             par;
        logic             line;
        logic             clk_prev;
        logic             started;
        logic             tbe_pend;
        logic             popped;
        logic             ext_pend;
        logic [3:0]       flt_lvl;
        logic [3:0][15:0] flt_cnt;
        logic [7:0]       vec_rb;
        logic [7:0]       rdata;
        logic             rvalid;
        logic             txd;
        logic             rx_en;
        logic             intr;
    } astc_chan_s;
    astc_chan_s s_q, s_d;

    logic       fifo_valid, fifo_ready, pop, flush, fall, cts_ok, ext_evt;
    logic [7:0] fifo_data;
    logic [6:0] div, stop_ticks, limit;
    logic [3:0] raw;
    logic [3:0] nbits;
    logic [7:0] masked;

    astc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_reset     (i_reset),
        .i_flush     (flush),
        .i_in_valid  (i_bus.wr && !i_bus.ctrl),
        .i_in_data   (i_bus.wdata),
        .o_in_ready  (fifo_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (pop)
    );

    always_comb begin
        s_d = s_q;
        flush = 1'b0;
        pop = 1'b0;
        ext_evt = 1'b0;
        fall = s_q.clk_prev && !i_transmit_bit_clock;
        div = astc_div(s_q.afc[AFC_CLK_LO +: 2]);
        // 1.5 stop bits rounds the half bit up so x1 still gives two edges
        case (s_q.afc[AFC_STOP_LO +: 2])
            2'b10:   stop_ticks = div + ((div == 7'd1) ? 7'd1 : (div >> 1));
            2'b11:   stop_ticks = 7'(div << 1);
            default: stop_ticks = div;
        endcase
        limit = (s_q.st == TX_STOP) ? stop_ticks : div;
        cts_ok = !s_q.rxc[RXC_AUTO] || !i_cts_n;
        nbits = astc_nbits(s_q.transmit_bit_clock[TXC_LEN_LO +: 2], fifo_data);
        masked = fifo_data & 8'((9'h001 << nbits) - 9'h001);
        s_d.clk_prev = i_transmit_bit_clock;

        // Transmit sequencer advances only on falling edges of the bit clock
        if (fall) begin
            case (s_q.st)
                TX_IDLE: begin
                    s_d.line = 1'b1;
                    if (fifo_valid && s_q.transmit_bit_clock[TXC_EN] && cts_ok) begin
                        pop = 1'b1;
                        s_d.sh = masked;
                        s_d.cnt = nbits - 4'd1;
                        s_d.par = (^masked) ^ !s_q.afc[AFC_EVEN];
                        s_d.st = TX_START;
                        s_d.line = 1'b0;
                        s_d.tick = '0;
                    end
                end
                default: begin
                    if (s_q.tick == limit - 7'd1) begin
                        s_d.tick = '0;
                        case (s_q.st)
                            TX_START: begin
                                s_d.st = TX_DATA;
                                s_d.line = s_q.sh[0];
                                s_d.sh = s_q.sh >> 1;
                            end
                            TX_DATA: begin
                                if (s_q.cnt != 4'd0) begin
                                    s_d.cnt = s_q.cnt - 4'd1;
                                    s_d.line = s_q.sh[0];
                                    s_d.sh = s_q.sh >> 1;
                                end else if (s_q.afc[AFC_PEN]) begin
                                    s_d.st = TX_PAR;
                                    s_d.line = s_q.par;
                                end else begin
                                    s_d.st = TX_STOP;
                                    s_d.line = 1'b1;
                                end
                            end
                            TX_PAR: begin
                                s_d.st = TX_STOP;
                                s_d.line = 1'b1;
                            end
                            TX_STOP: begin
                                s_d.st = TX_IDLE;
                                s_d.line = 1'b1;
                            end
                            default: s_d.st = TX_IDLE;
                        endcase
                    end else begin
                        s_d.tick = s_q.tick + 7'd1;
                    end
                end
            endcase
        end

        // Deglitch CTS, DCD, sync and a held-low receive line (break)
        raw = {!i_rxd, !i_sync_n, !i_dcd_n, !i_cts_n};
        for (int i = 0; i < 4; i++) begin
            if (raw[i] == s_q.flt_lvl[i]) begin
                s_d.flt_cnt[i] = '0;
            end else if (s_q.flt_cnt[i] == ((i == 3) ? BREAK_CYC : MIN_PULSE_CYC) - 16'd1) begin
                s_d.flt_cnt[i] = '0;
                s_d.flt_lvl[i] = raw[i];
                ext_evt = 1'b1;
            end else begin
                s_d.flt_cnt[i] = s_q.flt_cnt[i] + 16'd1;
            end
        end

        // Register port: pointer selects the next control write, then falls back
        s_d.rvalid = 1'b0;
        if (i_bus.wr && i_bus.ctrl) begin
            s_d.ptr = PTR_CMD;
            case (s_q.ptr)
                PTR_CMD: s_d.ptr = i_bus.wdata[2:0];
                PTR_IMR: s_d.imr = i_bus.wdata;
                PTR_VEC: s_d.vec = i_bus.wdata;
                PTR_RXC: s_d.rxc = i_bus.wdata;
                PTR_AFC: s_d.afc = i_bus.wdata;
                PTR_TXC: s_d.transmit_bit_clock = i_bus.wdata;
                default: s_d.ptr = PTR_CMD;
            endcase
        end
        if (i_bus.rd) begin
            s_d.rvalid = 1'b1;
            s_d.ptr = PTR_CMD;
            if (!i_bus.ctrl) s_d.rdata = RD_NONE;
            else if (s_q.ptr == PTR_VEC) s_d.rdata = s_q.vec_rb;
            else s_d.rdata = {s_q.flt_lvl[3], 1'b0, s_q.flt_lvl[0], s_q.flt_lvl[2],
                              s_q.flt_lvl[1], !fifo_valid, 2'b00};
        end
        if (i_iack) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = s_q.vec_rb;
        end

        // Pending causes; a new event wins over a clear in the same cycle
        if (i_bus.wr && !i_bus.ctrl) s_d.started = 1'b1;
        if ((i_bus.wr && !i_bus.ctrl) ||
            (i_bus.wr && i_bus.ctrl && s_q.ptr == PTR_CMD && i_bus.wdata[5:3] == CMD_RST_TXINT))
            s_d.tbe_pend = 1'b0;
        // Empty is judged a cycle after the pop, from the FIFO's own registered flag
        s_d.popped = pop;
        if (s_q.popped && !fifo_valid && s_q.started && s_q.imr[IMR_TXI])
            s_d.tbe_pend = 1'b1;
        if (i_bus.wr && i_bus.ctrl && s_q.ptr == PTR_CMD && i_bus.wdata[5:3] == CMD_RST_EXT)
            s_d.ext_pend = 1'b0;
        if (ext_evt && s_q.imr[IMR_EXT]) s_d.ext_pend = 1'b1;

        // This channel owns the shared vector; first channel outranks it
        s_d.vec_rb = s_q.vec;
        if (s_q.imr[IMR_SAV]) begin
            if (i_peer.req) s_d.vec_rb[3:1] = {1'b1, i_peer.cause};
            else if (s_q.tbe_pend) s_d.vec_rb[3:1] = VEC_TBE;
            else if (s_q.ext_pend) s_d.vec_rb[3:1] = VEC_EXT;
            else s_d.vec_rb[3:1] = VEC_SRC;
        end
        s_d.intr = i_peer.req || s_q.tbe_pend || s_q.ext_pend;

        if (i_bus.wr && i_bus.ctrl && s_q.ptr == PTR_CMD && i_bus.wdata[5:3] == CMD_CHAN_RST) begin
            flush = 1'b1;
            s_d.imr = REG_RESET;
            s_d.rxc = REG_RESET;
            s_d.afc = REG_RESET;
            s_d.transmit_bit_clock = REG_RESET;
            s_d.st = TX_IDLE;
            s_d.line = 1'b1;
            s_d.started = 1'b0;
            s_d.tbe_pend = 1'b0;
            s_d.ext_pend = 1'b0;
        end
        s_d.txd = s_d.line && !s_d.transmit_bit_clock[TXC_BRK];
        s_d.rx_en = s_d.rxc[RXC_EN] && (!s_d.rxc[RXC_AUTO] || !i_dcd_n);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s_q <= '0;
            s_q.st <= TX_IDLE;
            s_q.line <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.clk_prev <= 1'b1;
            s_q.flt_lvl <= 4'h0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_txd           = s_q.txd;
    assign o_rts_n         = !s_q.transmit_bit_clock[TXC_RTS];
    assign o_dtr_n         = !s_q.transmit_bit_clock[TXC_DTR];
    assign o_rx_enabled    = s_q.rx_en;
    assign o_rx_bits       = astc_nbits({s_q.rxc[RXC_LEN_LO], s_q.rxc[RXC_LEN_LO+1]} == 2'b00
                                        ? 2'b00 : s_q.rxc[RXC_LEN_LO +: 2], 8'h00);
    assign o_wait_ready_en = s_q.imr[IMR_WR];
    assign o_rx_int_mode   = s_q.imr[IMR_RXI_LO +: 2];
    assign o_int           = s_q.intr;
    assign o_rdata         = s_q.rdata;
    assign o_rvalid        = s_q.rvalid;
    assign o_tx_ready      = fifo_ready;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    property p_idle_mark;
        (s_q.st == TX_IDLE && !s_q.transmit_bit_clock[TXC_BRK]) |-> o_txd;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("idle line not marking");
    property p_break;
        s_q.transmit_bit_clock[TXC_BRK] |-> !o_txd;
    endproperty
    a_break: assert property (p_break) else $error("break not spacing");
    property p_start_low;
        (s_q.st == TX_START && !s_q.transmit_bit_clock[TXC_BRK]) |-> !o_txd;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");
    property p_stop_high;
        (s_q.st == TX_STOP && !s_q.transmit_bit_clock[TXC_BRK]) |-> o_txd;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
    property p_on_fall;
        $changed(s_q.line) |-> $past(s_q.clk_prev && !i_transmit_bit_clock);
    endproperty
    a_on_fall: assert property (p_on_fall) else $error("line moved off a falling edge");
    property p_enable;
        $rose(s_q.st == TX_START) |-> $past(s_q.transmit_bit_clock[TXC_EN]) && $past(cts_ok);
    endproperty
    a_enable: assert property (p_enable) else $error("start without enable or cts");
    property p_ext;
        (ext_evt && s_q.imr[IMR_EXT]) |=> s_q.ext_pend ##1 o_int;
    endproperty
    a_ext: assert property (p_ext) else $error("ext change lost");
    property p_first;
        !s_q.started |-> !s_q.tbe_pend;
    endproperty
    a_first: assert property (p_first) else $error("tx empty before first byte");
    property p_vec;
        (s_q.imr[IMR_SAV] && !i_peer.req && s_q.tbe_pend) |=> s_q.vec_rb[3:1] == VEC_TBE;
    endproperty
    a_vec: assert property (p_vec) else $error("vector cause wrong");
    property p_iack;
        i_iack |=> o_rvalid && o_rdata == $past(s_q.vec_rb);
    endproperty
    a_iack: assert property (p_iack) else $error("ack vector wrong");
    property p_peer;
        (s_q.imr[IMR_SAV] && i_peer.req) |=> s_q.vec_rb[3];
    endproperty
    a_peer: assert property (p_peer) else $error("first channel not ranked first");

    c_char: cover property ((s_q.st == TX_STOP) ##1 (s_q.st == TX_IDLE));
    c_par:  cover property (s_q.st == TX_PAR);
    c_full: cover property (!fifo_ready);
    c_ext:  cover property ($rose(s_q.ext_pend));
endmodule : astc_channel

// >>> testbench/astc_term.sv
// Remote terminal model: free x1 transmit bit clock and a frame receiver.
// Assumes frame settings come from the bench and only change between frames.
`timescale 1ns/1ps
module astc_term (
    input  wire logic       i_ref_clk, // Reference clock
    input  wire logic       i_txd,     // Serial line in
    input  wire logic [3:0] i_nbits,   // Data bits per character
    input  wire logic       i_par_en,  // Parity expected
    input  wire logic       i_even,    // Even parity
    output logic            o_bit_clk, // Bit clock, 8 ref cycles
    output logic            o_got,     // Character pulse
    output logic [7:0]      o_char,    // Received data
    output logic            o_par_ok,  // Parity matched
    output logic            o_stop_ok  // Stop bit high
);
    int         ph = 0;
    int         k  = -1;
    logic       p;
    logic [7:0] sh;
    initial o_bit_clk = 1'b1;
    initial o_got = 1'b0;
    always @(posedge i_ref_clk) begin
        o_got <= 1'b0;
        ph = (ph + 1) % 8;
        o_bit_clk <= (ph < 4);
        // Sample at the rise, half a bit after the channel shifts on the fall
        if (ph == 0) begin
            if (k < 0) begin
                if (!i_txd) begin
                    k = 0;
                    sh = 8'h00;
                    p = 1'b0;
                    o_par_ok <= 1'b1;
                end
            end else if (k < int'(i_nbits)) begin
                sh[k] = i_txd;
                p = p ^ i_txd;
                k++;
            end else if (k == int'(i_nbits) && i_par_en) begin
                o_par_ok <= ((p ^ i_txd) == !i_even);
                k++;
            end else begin
                o_char <= sh;
                o_stop_ok <= i_txd;
                o_got <= 1'b1;
                k = -1;
            end
        end
    end
endmodule : astc_term

// >>> testbench/astc_channel_tb_top.sv
// Self-checking bench for the asynchronous transmit channel with a terminal model.
// Assumes x1 clock mode and idle carrier, sync and receive lines.
`timescale 1ns/1ps
module astc_channel_tb_top import astc_pkg::*;;
    localparam logic [1:0] LC[4] = '{2'b11, 2'b01, 2'b10, 2'b00};
    localparam logic [7:0] AF[4] = '{8'h07, 8'h0d, 8'h08, 8'h07};
    logic       clk = 1'b0, rst = 1'b1, cts_n = 1'b1, par_en = 1'b0, even = 1'b0;
    logic       listen = 1'b1, iack = 1'b0;
    logic       rvalid, rxen, wre, irq;
    logic [1:0] rim;
    logic [7:0] rdata;
    logic [3:0] nb = 4'd8;
    astc_bus_s  bus = '0;
    logic       bclk, txd, got, pok, sok, rts_n, dtr_n, rdy;
    logic [7:0] ch;
    logic [3:0] rxb;
    logic [7:0] exp_q[$];
    int         n_errors = 0, n_tests = 0, cyc = 0, seed = 32'ha8742010;
    astc_channel uut (.i_ref_clk(clk), .i_reset(rst), .i_bus(bus), .i_iack(iack),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_tx_ready(rdy), .i_peer('0),
        .i_transmit_bit_clock(bclk),
        .i_rxd(1'b1), .i_cts_n(cts_n), .i_dcd_n(1'b1), .i_sync_n(1'b1), .o_txd(txd),
        .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_rx_enabled(rxen), .o_rx_bits(rxb),
        .o_wait_ready_en(wre), .o_rx_int_mode(rim), .o_int(irq));
    astc_term term (.i_ref_clk(clk), .i_txd(txd), .i_nbits(nb), .i_par_en(par_en),
        .i_even(even), .o_bit_clk(bclk), .o_got(got), .o_char(ch), .o_par_ok(pok),
        .o_stop_ok(sok));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic put(input logic c, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, ctrl: c, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask : put
    task automatic setreg(input logic [2:0] ptr, input logic [7:0] v);
        put(1'b1, {5'h00, ptr});
        put(1'b1, v);
    endtask : setreg
    task automatic send(input logic [1:0] len);
        logic [7:0] b;
        b = 8'($random(seed));
        // Leading zero marker asks for five data bits
        if (len == 2'b00) b[7] = 1'b0;
        // One edge first so the previous push is already seen in the ready flag
        @(posedge clk);
        for (int i = 0; i < 300 && !rdy; i++) @(posedge clk);
        if (!rdy) n_errors++;
        exp_q.push_back(b & 8'((1 << nb) - 1));
        put(1'b0, b);
    endtask : send
    task automatic ask(input logic use_ack, input logic [7:0] want);
        @(posedge clk);
        if (use_ack) iack <= 1'b1;
        else bus <= '{wr: 1'b0, rd: 1'b1, ctrl: 1'b1, wdata: 8'h00};
        @(posedge clk);
        iack <= 1'b0;
        bus <= '0;
        @(posedge clk);
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, want);
    endtask : ask
    task automatic drain(input int lim);
        for (int i = 0; i < lim && exp_q.size() > 0; i++) @(posedge clk);
    endtask : drain
    task automatic report_and_stop;
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop();
        end
        if (got && listen) begin
            chk(ch, exp_q.pop_front());
            chk({7'h00, pok}, 8'h01);
            chk({7'h00, sok}, 8'h01);
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({6'h00, txd, rts_n}, 8'h03);
        put(1'b1, {2'b00, CMD_CHAN_RST, 3'h0}); // Channel reset comes first
        for (int c = 0; c < 4; c++) begin
            nb <= 4'(8 - c);
            par_en <= AF[c][AFC_PEN];
            even <= AF[c][AFC_EVEN];
            setreg(PTR_AFC, AF[c]);
            setreg(PTR_RXC, {LC[c], 6'h01});
            setreg(PTR_TXC, {1'b1, LC[c], 5'h0a});
            @(posedge clk);
            chk({4'h0, rxb}, {4'h0, nb});
            chk({6'h00, dtr_n, rts_n}, 8'h00);
            chk({7'h00, rxen}, 8'h01);
            repeat (5) send(LC[c]);
            drain(3000);
            chk(8'(exp_q.size()), 8'h00);
            // Let the last stop bits finish before the format changes
            repeat (40) @(posedge clk);
        end
        setreg(PTR_TXC, 8'hfa);
        listen <= 1'b0;
        repeat (40) @(posedge clk);
        chk({7'h00, txd}, 8'h00);
        setreg(PTR_TXC, 8'hea);
        repeat (200) @(posedge clk);
        chk({7'h00, txd}, 8'h01);
        listen <= 1'b1;
        nb <= 4'd8;
        setreg(PTR_RXC, 8'he1);
        setreg(PTR_TXC, 8'he2);
        chk({7'h00, rxen}, 8'h00);
        send(2'b11);
        repeat (200) @(posedge clk);
        chk(8'(exp_q.size()), 8'h01);
        setreg(PTR_TXC, 8'hea);
        repeat (200) @(posedge clk);
        chk(8'(exp_q.size()), 8'h01);
        cts_n <= 1'b0;
        drain(400);
        chk(8'(exp_q.size()), 8'h00);
        setreg(PTR_VEC, 8'h4f);
        setreg(PTR_IMR, 8'h9f);
        @(posedge clk);
        chk({5'h00, wre, rim}, 8'h07);
        send(2'b11);
        drain(400);
        repeat (4) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        ask(1'b1, {4'h4, VEC_TBE, 1'b1});
        cts_n <= 1'b1;
        repeat (20) @(posedge clk);
        put(1'b1, {2'b00, CMD_RST_TXINT, 3'h0});
        repeat (3) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        ask(1'b1, {4'h4, VEC_EXT, 1'b1});
        ask(1'b0, 8'h04);
        report_and_stop();
    end
endmodule : astc_channel_tb_top
